// file: sfc_core.sv
// Serial flash instruction decoder: enable latch, status and read paths
//
// Overview of operation
// - 06h sets write enable latch
// - Status write refused unless latch set
// - 04h clears write enable latch
// - Latch cleared at reset and write completion
// - Status shifted out MSB first, falling edges
// - Status reads accepted even while busy
// - Status byte repeats until select rises
// - 01h plus one or two bytes, latch needed
// - Status write changes only lock, protect and quad bits
// - Status write only on bit 8 or 16
// - Eight-bit write clears quad and second lock
// - Valid write starts timed busy cycle
// - Protect bits exported to array control
// - Status bits default to zero
// - Read code plus 24-bit address, rising edges
// - Data MSB first, address auto-increments
// - Plain read ignored while busy
// - Fast read inserts eight dummy clocks
// - Dual read drives two bits per clock
// - Busy ignores all but status reads
// - Write aborted if select rises mid-byte
// - Select fall starts decode, first byte opcode
`timescale 1ns/10ps
`default_nettype none
`include "sfc_map.svh"
module sfc_core import sfc_pkg::*; #(
  parameter int TW_CYCLES = `SFC_TW_CYCLES,
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       cs_n_pin,
  input  wire logic       sclk_pin,
  input  wire logic       io0_in,
  input  wire logic       io1_in,
  output logic            io0_out,
  output logic            io0_oe,
  output logic            io1_out,
  output logic            io1_oe,
  output logic [23:0]     mem_addr,
  output logic            mem_req,
  input  wire logic [7:0] mem_data,
  input  wire logic       mem_valid,
  output logic            mem_ready,
  output logic [4:0]      protect_bits,
  output logic            busy
);
  logic [2:0] cs_sync_q;
  logic [2:0] clk_sync_q;
  logic [1:0] d0_sync_q;
  logic [1:0] d1_sync_q;
  logic       cs_low;
  logic       cs_fall;
  logic       cs_rise;
  logic       rise;
  logic       fall;
  sfc_state_e st_q;
  logic [7:0]  sh_q;
  logic [3:0]  bit_q;
  logic [7:0]  op_q;
  logic [4:0]  abit_q;
  logic [23:0] addr_q;
  logic [3:0]  dcnt_q;
  logic [4:0]  wcnt_q;
  logic [15:0] wdat_q;
  logic [7:0]  sr_lo_q;
  logic [7:0]  sr_hi_q;
  logic        wel_q;
  logic        busy_q;
  logic [31:0] tw_q;
  logic [7:0]  out_q;
  logic [3:0]  obit_q;
  logic        is_status_rd;
  logic        is_dual;
  logic [7:0]  sample_byte;
  logic        f_valid;
  logic [7:0]  f_data;
  logic        f_ready;
  logic        f_in_ready;
  logic        fetch_q;
  logic        flush;

  // Pins cross into core_clk; only stage two onward feeds logic
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cs_sync_q  <= 3'h7;
      clk_sync_q <= 3'h0;
      d0_sync_q  <= 2'h0;
      d1_sync_q  <= 2'h0;
    end else begin
      cs_sync_q  <= {cs_sync_q[1:0], cs_n_pin};
      clk_sync_q <= {clk_sync_q[1:0], sclk_pin};
      d0_sync_q  <= {d0_sync_q[0], io0_in};
      d1_sync_q  <= {d1_sync_q[0], io1_in};
    end
  end
  assign cs_low  = !cs_sync_q[1];
  assign cs_fall = cs_sync_q[2] && !cs_sync_q[1];
  assign cs_rise = !cs_sync_q[2] && cs_sync_q[1];
  assign rise    = cs_low && !clk_sync_q[2] && clk_sync_q[1];
  assign fall    = cs_low && clk_sync_q[2] && !clk_sync_q[1];
  assign sample_byte  = {sh_q[6:0], d0_sync_q[1]};
  assign is_status_rd = (op_q == `SFC_OP_RDSR_LO) || (op_q == `SFC_OP_RDSR_HI);
  assign is_dual      = (op_q == `SFC_OP_DREAD);
  assign flush        = cs_rise || cs_fall;

  // Decoder state, opcode capture and address / data shifting
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q   <= SFC_IDLE;
      sh_q   <= 8'h00;
      bit_q  <= 4'h0;
      op_q   <= 8'h00;
      abit_q <= 5'h00;
      addr_q <= 24'h00_0000;
      dcnt_q <= 4'h0;
      wcnt_q <= 5'h00;
      wdat_q <= 16'h0000;
    end else if (!cs_low) begin
      st_q  <= SFC_IDLE;
      bit_q <= 4'h0;
    end else begin
      case (st_q)
        SFC_IDLE: begin
          if (cs_fall) begin
            st_q  <= SFC_OPC;
            bit_q <= 4'h0;
          end
        end
        SFC_OPC: begin
          if (rise) begin
            sh_q  <= sample_byte;
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              op_q <= sample_byte;
              if (busy_q && sample_byte != `SFC_OP_RDSR_LO
                  && sample_byte != `SFC_OP_RDSR_HI) begin
                st_q <= SFC_IGN;
              end else begin
                case (sample_byte)
                  `SFC_OP_RDSR_LO, `SFC_OP_RDSR_HI: st_q <= SFC_DATA;
                  `SFC_OP_READ, `SFC_OP_FREAD, `SFC_OP_DREAD: begin
                    st_q   <= SFC_ADDR;
                    abit_q <= 5'h00;
                  end
                  `SFC_OP_WRSR: begin
                    st_q   <= SFC_WDAT;
                    wcnt_q <= 5'h00;
                  end
                  `SFC_OP_WREN, `SFC_OP_WRDI: st_q <= SFC_IGN;
                  default: st_q <= SFC_IGN;
                endcase
              end
            end
          end
        end
        SFC_ADDR: begin
          if (rise) begin
            addr_q <= {addr_q[22:0], d0_sync_q[1]};
            abit_q <= abit_q + 5'h01;
            if (abit_q == 5'(`SFC_ADDR_BITS - 1)) begin
              dcnt_q <= 4'h0;
              st_q   <= (op_q == `SFC_OP_READ) ? SFC_DATA : SFC_DUMMY;
            end
          end
        end
        SFC_DUMMY: begin
          if (rise) begin
            dcnt_q <= dcnt_q + 4'h1;
            if (dcnt_q == 4'(`SFC_DUMMY_CLKS - 1)) begin
              st_q <= SFC_DATA;
            end
          end
        end
        SFC_WDAT: begin
          if (rise) begin
            wdat_q <= {wdat_q[14:0], d0_sync_q[1]};
            wcnt_q <= (wcnt_q == 5'h1F) ? wcnt_q : wcnt_q + 5'h01;
          end
        end
        SFC_DATA: begin
          if (fetch_q) begin
            addr_q <= addr_q + 24'h00_0001;
          end
        end
        SFC_IGN: begin
          // count bits, holding at 15, so a stray ninth bit voids the enable byte
          if (rise && bit_q != 4'hF) begin
            bit_q <= bit_q + 4'h1;
          end
        end
        default: st_q <= SFC_IDLE;
      endcase
    end
  end

  // Status registers, write enable latch and self-timed write cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sr_lo_q <= `SFC_SR_RESET;
      sr_hi_q <= `SFC_SR_RESET;
      wel_q   <= 1'b0;
      busy_q  <= 1'b0;
      tw_q    <= 32'h0000_0000;
    end else begin
      if (busy_q) begin
        if (tw_q == 32'h0000_0001) begin
          busy_q <= 1'b0;
          wel_q  <= 1'b0;
        end
        tw_q <= tw_q - 32'h0000_0001;
      end else if (cs_rise && bit_q == 4'h8 && st_q == SFC_IGN) begin
        if (op_q == `SFC_OP_WREN) begin
          wel_q <= 1'b1;
        end
        if (op_q == `SFC_OP_WRDI) begin
          wel_q <= 1'b0;
        end
      end else if (cs_rise && st_q == SFC_WDAT && wel_q) begin
        // only 8 or 16 whole bits, latch set
        if (wcnt_q == 5'd8 || wcnt_q == 5'd16) begin
          sr_lo_q <= (sr_lo_q & ~`SFC_LO_WMASK)
                   | ((wcnt_q == 5'd8 ? wdat_q[7:0] : wdat_q[15:8]) & `SFC_LO_WMASK);
          // eight bits clear quad and second lock
          sr_hi_q <= (sr_hi_q & ~`SFC_HI_WMASK)
                   | ((wcnt_q == 5'd8 ? 8'h00 : wdat_q[7:0]) & `SFC_HI_WMASK);
          busy_q <= 1'b1;
          tw_q   <= 32'(TW_CYCLES);
        end
      end
    end
  end

  // Read data comes through the FIFO; array stalls are absorbed here
  always_ff @(posedge core_clk) begin
    if (!rst_n || !cs_low) begin
      fetch_q <= 1'b0;
    end else begin
      fetch_q <= (st_q == SFC_DATA) && !is_status_rd && f_in_ready
                 && !fetch_q && !mem_req_q_pending();
    end
  end
  function automatic logic mem_req_q_pending();
    return f_valid;
  endfunction

  sfc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .flush     (flush),
    .in_data   (mem_data),
    .in_valid  (mem_valid),
    .in_ready  (f_in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );
  assign f_ready = (st_q == SFC_DATA) && !is_status_rd && fall && obit_q == 4'h0;

  always_ff @(posedge core_clk) begin
    if (!rst_n || !cs_low || st_q != SFC_DATA) begin
      out_q   <= 8'h00;
      obit_q  <= 4'h0;
      io0_out <= 1'b0;
      io1_out <= 1'b0;
      io0_oe  <= 1'b0;
      io1_oe  <= 1'b0;
    end else if (fall) begin
      if (obit_q == 4'h0) begin
        if (is_status_rd) begin
          out_q <= (op_q == `SFC_OP_RDSR_LO)
                   ? {sr_lo_q[7:2], wel_q, busy_q} : sr_hi_q;
        end else begin
          out_q <= f_data;
        end
      end
      if (is_dual) begin
        io0_oe  <= 1'b1;
        io1_oe  <= 1'b1;
        io1_out <= (obit_q == 4'h0) ? f_data[7] : out_q[7 - 2 * obit_q[1:0]];
        io0_out <= (obit_q == 4'h0) ? f_data[6] : out_q[6 - 2 * obit_q[1:0]];
        obit_q  <= (obit_q == 4'h3) ? 4'h0 : obit_q + 4'h1;
      end else begin
        io1_oe  <= 1'b1;
        io1_out <= (obit_q == 4'h0)
                   ? (is_status_rd ? ((op_q == `SFC_OP_RDSR_LO) ? sr_lo_q[7] : sr_hi_q[7])
                                   : f_data[7])
                   : out_q[3'(7 - obit_q)];
        obit_q  <= (obit_q == 4'h7) ? 4'h0 : obit_q + 4'h1;
      end
    end
  end

  // protect field handed to array control; reads blocked via
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mem_addr     <= 24'h00_0000;
      mem_req      <= 1'b0;
      mem_ready    <= 1'b0;
      protect_bits <= 5'h00;
      busy         <= 1'b0;
    end else begin
      mem_addr     <= addr_q;
      mem_req      <= fetch_q;
      mem_ready    <= f_in_ready;
      protect_bits <= sr_lo_q[6:2];
      busy         <= busy_q;
    end
  end
endmodule
`default_nettype wire

// file: sfc_map.svh
// Constants for the serial flash instruction decoder
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH
`define SFC_OP_WREN      8'h06
`define SFC_OP_WRDI      8'h04
`define SFC_OP_RDSR_LO   8'h05
`define SFC_OP_RDSR_HI   8'h35
`define SFC_OP_WRSR      8'h01
`define SFC_OP_READ      8'h03
`define SFC_OP_FREAD     8'h0B
`define SFC_OP_DREAD     8'h3B
`define SFC_BIT_BUSY     0
`define SFC_BIT_WEL      1
`define SFC_LO_WMASK     8'hBC
`define SFC_HI_WMASK     8'h03
`define SFC_SR_RESET     8'h00
`define SFC_ADDR_BITS    24
`define SFC_DUMMY_CLKS   8
`define SFC_CLK_MHZ      200
`define SFC_TW_US        10
`define SFC_TW_CYCLES    (`SFC_TW_US * `SFC_CLK_MHZ)
`endif

// file: sfc_pkg.sv
// Types for the serial flash instruction decoder
package sfc_pkg;
  typedef enum logic [6:0] {
    SFC_IDLE  = 7'b000_0001,
    SFC_OPC   = 7'b000_0010,
    SFC_ADDR  = 7'b000_0100,
    SFC_DUMMY = 7'b000_1000,
    SFC_DATA  = 7'b001_0000,
    SFC_WDAT  = 7'b010_0000,
    SFC_IGN   = 7'b100_0000
  } sfc_state_e;
endpackage

// file: sfc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: sfc_core_monitor.sv
// Concurrent checks on the serial flash decoder's pins
`timescale 1ns/10ps
`default_nettype none
module sfc_core_monitor #(
  parameter int TW_CYCLES = 2000
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       cs_n_pin,
  input wire logic       sclk_pin,
  input wire logic       io0_oe,
  input wire logic       io1_out,
  input wire logic       io1_oe,
  input wire logic       mem_req,
  input wire logic [4:0] protect_bits,
  input wire logic       busy
);
  logic [15:0] busy_cnt_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge core_clk) begin
    if (!rst_n || !busy) begin
      busy_cnt_q <= 16'h0000;
    end else begin
      busy_cnt_q <= busy_cnt_q + 16'h0001;
    end
  end
  oe_idle_a: assert property (cs_n_pin [*8] |-> !io1_oe && !io0_oe)
    else $error("line driven while deselected");
  req_idle_a: assert property (cs_n_pin [*8] |-> !mem_req)
    else $error("array fetch while deselected");
  dual_pair_a: assert property (io0_oe |-> io1_oe)
    else $error("line zero driven alone");
  shift_edge_a: assert property ($changed(io1_out) && io1_oe && $past(io1_oe)
    |-> !sclk_pin && !$past(sclk_pin, 2))
    else $error("output bit moved away from a falling edge");
  busy_start_a: assert property ($rose(busy) |-> cs_n_pin)
    else $error("busy began inside a frame");
  busy_max_a: assert property (busy |-> busy_cnt_q <= TW_CYCLES + 4)
    else $error("write cycle too long");
  busy_min_a: assert property ($fell(busy) |-> busy_cnt_q >= TW_CYCLES - 4)
    else $error("write cycle too short");
  busy_fetch_a: assert property (busy |-> !mem_req && !io0_oe)
    else $error("read served while busy");
  prot_write_a: assert property ($changed(protect_bits) |-> $rose(busy))
    else $error("protect bits moved without a write cycle");
  cover property ($fell(busy));
  cover property ($rose(io0_oe));
  cover property ($rose(mem_req));
endmodule
bind sfc_core sfc_core_monitor #(.TW_CYCLES(TW_CYCLES)) sfc_core_monitor_inst (
  .core_clk(core_clk), .rst_n(rst_n), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
  .io0_oe(io0_oe), .io1_out(io1_out), .io1_oe(io1_oe), .mem_req(mem_req),
  .protect_bits(protect_bits), .busy(busy)
);
`default_nettype wire

// file: sfc_host_model.sv
// Serial host model that frames instructions towards the decoder
`timescale 1ns/10ps
`default_nettype none
module sfc_host_model (
  input  wire logic core_clk,
  input  wire logic io0_pin,
  input  wire logic io1_pin,
  output logic      cs_n,
  output logic      sclk,
  output logic      mosi,
  output logic      mosi_oe
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    mosi_oe = 1'b1;
  end
  task automatic frame(input logic [39:0] tx, input int ntx, input int nclk,
                       input logic dual, output logic [31:0] rx);
    rx = '0;
    cs_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    for (int i = 0; i < ntx + nclk; i++) begin
      if (i < ntx) mosi <= tx[39 - i];
      repeat (16) @(posedge core_clk);
      sclk <= 1'b1;
      if (i >= ntx) rx = dual ? {rx[29:0], io1_pin, io0_pin} : {rx[30:0], io1_pin};
      // let go of line zero before the first data fall
      if (dual && i == ntx - 1) mosi_oe <= 1'b0;
      repeat (16) @(posedge core_clk);
      sclk <= 1'b0;
    end
    repeat (16) @(posedge core_clk);
    // select rises after the last whole bit sent
    cs_n <= 1'b1;
    mosi_oe <= 1'b1;
    repeat (16) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// file: serial_flash_cmd_status_read_tb.sv
// Self-checking bench for the serial flash instruction decoder
`timescale 1ns/10ps
`default_nettype none
module serial_flash_cmd_status_read_tb;
  typedef struct packed {
    logic [39:0] tx;
    logic [7:0]  ntx;
    logic [7:0]  nclk;
    logic        dual;
    logic        nw;
    logic [15:0] exp;
    logic [15:0] mask;
  } sfc_row_s;
  localparam int NR = 24;
  // Rows run in order; nw skips the wait for busy to drop
  localparam sfc_row_s ROWS [NR] = '{
    '{40'h05_0000_0000, 8, 16, 0, 0, 16'h0000, 16'hFFFF}, '{40'h06_0000_0000, 8, 0, 0, 0, 0, 0},
    '{40'h05_0000_0000, 8, 16, 0, 0, 16'h0202, 16'hFFFF}, '{40'h04_0000_0000, 8, 0, 0, 0, 0, 0},
    '{40'h05_0000_0000, 8, 8, 0, 0, 16'h0000, 16'h00FF}, '{40'h01_FFFF_0000, 24, 0, 0, 0, 0, 0},
    '{40'h05_0000_0000, 8, 8, 0, 0, 16'h0000, 16'h00FF}, '{40'h06_0000_0000, 8, 0, 0, 0, 0, 0},
    '{40'h01_FF03_0000, 24, 0, 0, 0, 0, 0}, '{40'h05_0000_0000, 8, 8, 0, 1, 16'h00BF, 16'h00FF},
    '{40'h05_0000_0000, 8, 8, 0, 0, 16'h00BC, 16'h00FF},
    '{40'h35_0000_0000, 8, 8, 0, 0, 16'h0003, 16'h00FF}, '{40'h06_0000_0000, 8, 0, 0, 0, 0, 0},
    '{40'h01_0000_0000, 16, 0, 0, 0, 0, 0}, '{40'h35_0000_0000, 8, 8, 0, 0, 16'h0000, 16'h00FF},
    '{40'h06_0000_0000, 8, 0, 0, 0, 0, 0}, '{40'h01_FFF0_0000, 20, 0, 0, 0, 0, 0},
    '{40'h05_0000_0000, 8, 8, 0, 0, 16'h0000, 16'h00FC}, '{40'h04_0000_0000, 8, 0, 0, 0, 0, 0},
    '{40'h06_0000_0000, 9, 0, 0, 0, 0, 0}, '{40'hA5_0600_0000, 16, 0, 0, 0, 0, 0},
    '{40'h05_0000_0000, 8, 8, 0, 0, 16'h0000, 16'h00FF},
    '{40'h03_0000_1000, 32, 16, 0, 0, 16'h4A4B, 16'hFFFF},
    '{40'h0B_0000_FF00, 40, 16, 0, 0, 16'hA55A, 16'hFFFF}
  };
  logic core_clk, rst_n, cs_n, sclk, mosi, mosi_oe, io0_in, io1_in;
  logic io0_out, io0_oe, io1_out, io1_oe, mem_req, mem_valid, mem_ready, busy;
  logic [23:0] mem_addr;
  logic [7:0]  mem_data;
  logic [4:0]  protect_bits;
  logic [31:0] rx;
  int          n_errors, checks_done;
  assign io0_in = io0_oe ? io0_out : (mosi_oe ? mosi : ~mosi);
  assign io1_in = io1_oe ? io1_out : ~io1_out;
  sfc_core #(.TW_CYCLES(1200)) sfc_core_inst (
    .core_clk(core_clk), .rst_n(rst_n), .cs_n_pin(cs_n), .sclk_pin(sclk),
    .io0_in(io0_in), .io1_in(io1_in), .io0_out(io0_out), .io0_oe(io0_oe),
    .io1_out(io1_out), .io1_oe(io1_oe), .mem_addr(mem_addr), .mem_req(mem_req),
    .mem_data(mem_data), .mem_valid(mem_valid), .mem_ready(mem_ready),
    .protect_bits(protect_bits), .busy(busy)
  );
  sfc_host_model sfc_host_model_inst (
    .core_clk(core_clk), .io0_pin(io0_in), .io1_pin(io1_in), .cs_n(cs_n),
    .sclk(sclk), .mosi(mosi), .mosi_oe(mosi_oe)
  );
  // Array answers the next cycle with a byte derived from the address
  always @(posedge core_clk) begin
    mem_valid <= mem_req;
    mem_data <= mem_addr[7:0] ^ 8'h5A;
  end
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (90000) @(posedge core_clk);
    n_errors++;
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    n_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (int r = 0; r < NR; r++) begin
      for (int k = 0; k < 5000 && !ROWS[r].nw && busy !== 1'b0; k++) @(posedge core_clk);
      sfc_host_model_inst.frame(ROWS[r].tx, ROWS[r].ntx, ROWS[r].nclk, 1'b0, rx);
      if (ROWS[r].mask != 16'h0000) chk_word(rx[15:0] & ROWS[r].mask, ROWS[r].exp);
    end
    chk_word({11'h000, protect_bits}, 16'h0000);
    chk_flag(mem_ready, 1'b1);
    sfc_host_model_inst.frame(40'h3B_0000_2000, 40, 8, 1'b1, rx);
    chk_word(rx[15:0], 16'h7A7B);
    sfc_host_model_inst.frame(40'h06_0000_0000, 8, 0, 1'b0, rx);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk_flag(busy, 1'b0);
    chk_flag(io1_oe, 1'b0);
    repeat (4) @(posedge core_clk);
    sfc_host_model_inst.frame(40'h05_0000_0000, 8, 8, 1'b0, rx);
    chk_word({8'h00, rx[7:0]}, 16'h0000);
    finish_test();
  end
endmodule
`default_nettype wire
